/* verilog/pif_pkg.sv */
/*
 * constants for the peripheral interrupt flag block: register offsets, field
 * positions, reset values and the capture/compare mode codes.
 * assumes a 32-bit ahb-lite register bus, each register one aligned word.
 */
package pif_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_CORE_IRQ_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_OPTION_CONFIG         = 8'h04;
  localparam logic [7:0] OFS_PERIPHERAL_FLAGS_1    = 8'h08;
  localparam logic [7:0] OFS_PERIPHERAL_FLAGS_2    = 8'h0C;
  localparam logic [7:0] OFS_PERIPHERAL_ENABLES_1  = 8'h10;
  localparam logic [7:0] OFS_PERIPHERAL_ENABLES_2  = 8'h14;
  localparam logic [7:0] OFS_CCP2_MODE             = 8'h18;
  localparam logic [7:0] OFS_EVENT_STATUS          = 8'h1C;
  localparam logic [7:0] OFS_EVENT_MASK            = 8'h20;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          GIE_BIT           = 7;
  localparam int          PEIE_BIT          = 6;
  localparam int          CCP2_FLAG_BIT     = 0;
  localparam logic [7:0]  RST_CORE_IRQ      = 8'h00;
  localparam logic [7:0]  RST_OPTION        = 8'hFF;
  localparam logic [7:0]  RST_FLAGS         = 8'h00;
  localparam logic [7:0]  RST_ENABLES       = 8'h00;
  localparam logic [7:0]  FLAGS_2_MASK      = 8'h01;
  localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;
  localparam int          EVENT_CAPTURE     = 0;
  localparam int          EVENT_COMPARE     = 1;
  localparam int          EVENT_COUNT       = 2;

  // ****************************************************************
  // capture/compare mode of the second unit
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_COMPARE = 2'b10,
    MODE_PWM     = 2'b11
  } ccp_mode_t;

endpackage

/* verilog/pif_sticky_bits.sv */
/*
 * bank of sticky status bits, set by hardware, cleared by writing a one.
 * assumes set and clear vectors are single-cycle qualified.
 */
module pif_sticky_bits #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk_i, // core clock
  input  wire logic             rst_i,     // sync reset, high
  input  wire logic [WIDTH-1:0] set_i,     // hardware set pulses
  input  wire logic [WIDTH-1:0] clr_i,     // software clear pulses
  output logic      [WIDTH-1:0] bits_o     // sticky state
);

  // ****************************************************************
  // one flop per bit
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic bit_reg;
      wire  bit_next = set_i[g] | (bit_reg & ~clr_i[g]); // set beats clear
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) bit_reg <= 1'b0;
        else bit_reg <= bit_next;
      end
      assign bits_o[g] = bit_reg;
    end
  endgenerate

endmodule

/* verilog/pif_ahb_slave.sv */
/*
 * ahb-lite slave front end: captures the address phase, raises a one-cycle
 * write or read strobe in the data phase. always ready, always okay.
 * assumes single word transfers from one master.
 */
module pif_ahb_slave (
  input  wire logic        ref_clk_i,  // core clock
  input  wire logic        rst_i,      // sync reset, high
  input  wire logic        hsel_i,     // slave select
  input  wire logic [31:0] haddr_i,    // address
  input  wire logic [1:0]  htrans_i,   // transfer type
  input  wire logic        hwrite_i,   // write
  input  wire logic        hready_i,   // bus ready
  output logic             wr_o,       // write strobe, data phase
  output logic             rd_o,       // read strobe, data phase
  output logic [7:0]       addr_o      // latched byte offset
);

  // ****************************************************************
  // address phase capture
  // ****************************************************************
  logic       wr_reg;
  logic       rd_reg;
  logic [7:0] addr_reg;
  wire        take = hsel_i & hready_i & htrans_i[1];

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr_reg   <= 1'b0;
      rd_reg   <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_reg   <= take & hwrite_i;
      rd_reg   <= take & ~hwrite_i;
      if (take) addr_reg <= haddr_i[7:0];
    end
  end

  assign wr_o   = wr_reg;
  assign rd_o   = rd_reg;
  assign addr_o = addr_reg;

endmodule

/* verilog/peripheral_interrupt_flags.sv */
/*
 * peripheral interrupt flag and enable logic with a register file on
 * ahb-lite; the second capture/compare unit sets its flag on capture or
 * compare-match pulses, gated by mode.
 * assumes event pulses are one cycle and synchronous to ref_clk_i.
 */
// Overview of operation
// - flags set regardless of any enable
// - upper bits of flag reg two read zero
// - capture event sets bit zero in capture mode only, software clears
// - compare match sets flag in compare mode only; ignored in off, capture and pwm
module peripheral_interrupt_flags (
  input  wire logic        ref_clk_i,        // core clock, 250 mhz
  input  wire logic        rst_i,            // sync reset, high
  input  wire logic        hsel_i,           // ahb select
  input  wire logic [31:0] haddr_i,          // ahb address
  input  wire logic [1:0]  htrans_i,         // ahb transfer type
  input  wire logic        hwrite_i,         // ahb write
  input  wire logic [2:0]  hsize_i,          // ahb size, word only
  input  wire logic [31:0] hwdata_i,         // ahb write data
  input  wire logic        hready_i,         // ahb ready in
  output logic [31:0]      hrdata_o,         // ahb read data
  output logic             hreadyout_o,      // ahb ready out
  output logic             hresp_o,          // ahb response
  input  wire logic [7:0]  flags_1_set_i,    // set pulses, flag reg one
  input  wire logic        capture_event_i,  // timer count captured
  input  wire logic        compare_event_i,  // timer compare match
  output logic [1:0]       ccp_mode_o,       // second unit mode
  output logic             cpu_irq_o,        // core interrupt request
  output logic             irq_o             // event status interrupt
);

  // ****************************************************************
  // bus front end
  // ****************************************************************
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_addr;

  pif_ahb_slave u_bus (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .hsel_i    (hsel_i),
    .haddr_i   (haddr_i),
    .htrans_i  (htrans_i),
    .hwrite_i  (hwrite_i),
    .hready_i  (hready_i),
    .wr_o      (bus_wr),
    .rd_o      (bus_rd),
    .addr_o    (bus_addr)
  );

  wire [7:0] wdata = hwdata_i[7:0];
  wire wr_core = bus_wr & (bus_addr == pif_pkg::OFS_CORE_IRQ_CONTROL);
  wire wr_opt  = bus_wr & (bus_addr == pif_pkg::OFS_OPTION_CONFIG);
  wire wr_f1   = bus_wr & (bus_addr == pif_pkg::OFS_PERIPHERAL_FLAGS_1);
  wire wr_f2   = bus_wr & (bus_addr == pif_pkg::OFS_PERIPHERAL_FLAGS_2);
  wire wr_e1   = bus_wr & (bus_addr == pif_pkg::OFS_PERIPHERAL_ENABLES_1);
  wire wr_e2   = bus_wr & (bus_addr == pif_pkg::OFS_PERIPHERAL_ENABLES_2);
  wire wr_mode = bus_wr & (bus_addr == pif_pkg::OFS_CCP2_MODE);
  wire wr_sts  = bus_wr & (bus_addr == pif_pkg::OFS_EVENT_STATUS);
  wire wr_msk  = bus_wr & (bus_addr == pif_pkg::OFS_EVENT_MASK);

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [7:0]         core_irq_control_reg;
  logic [7:0]         option_config_reg;
  logic [7:0]         peripheral_enables_1_reg;
  logic               capture_compare_two_enable_reg;
  pif_pkg::ccp_mode_t ccp_mode_reg;
  logic [pif_pkg::EVENT_COUNT-1:0] event_mask_reg;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      core_irq_control_reg           <= pif_pkg::RST_CORE_IRQ;
      option_config_reg              <= pif_pkg::RST_OPTION;
      peripheral_enables_1_reg       <= pif_pkg::RST_ENABLES;
      capture_compare_two_enable_reg <= 1'b0;
      ccp_mode_reg                   <= pif_pkg::MODE_OFF;
      event_mask_reg                 <= '0;
    end else begin
      if (wr_core) core_irq_control_reg <= wdata;
      if (wr_opt)  option_config_reg <= wdata;
      if (wr_e1)   peripheral_enables_1_reg <= wdata;
      if (wr_e2)   capture_compare_two_enable_reg <= wdata[pif_pkg::CCP2_FLAG_BIT];
      if (wr_mode) ccp_mode_reg <= pif_pkg::ccp_mode_t'(wdata[1:0]);
      if (wr_msk)  event_mask_reg <= wdata[pif_pkg::EVENT_COUNT-1:0];
    end
  end

  // ****************************************************************
  // flag register one: set by peripherals, written by software
  // ****************************************************************
  logic [7:0] peripheral_flags_1_reg;
  logic [7:0] peripheral_flags_1_next;

  // writes store data; any set pulse still forces the bit high
  assign peripheral_flags_1_next = wr_f1 ? (wdata | flags_1_set_i)
                                         : (peripheral_flags_1_reg | flags_1_set_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) peripheral_flags_1_reg <= pif_pkg::RST_FLAGS;
    else peripheral_flags_1_reg <= peripheral_flags_1_next;
  end

  // ****************************************************************
  // flag register two: capture/compare unit two
  // ****************************************************************
  wire cap_hit = capture_event_i & (ccp_mode_reg == pif_pkg::MODE_CAPTURE);
  wire cmp_hit = compare_event_i & (ccp_mode_reg == pif_pkg::MODE_COMPARE);
  // pwm and off modes never reach the flag
  wire ccp2_set = cap_hit | cmp_hit;

  logic capture_compare_two_flag_reg;
  logic capture_compare_two_flag_next;

  // only a software write clears it; set takes priority
  assign capture_compare_two_flag_next =
    ccp2_set ? 1'b1 :
    wr_f2    ? wdata[pif_pkg::CCP2_FLAG_BIT] :
               capture_compare_two_flag_reg;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) capture_compare_two_flag_reg <= 1'b0;
    else capture_compare_two_flag_reg <= capture_compare_two_flag_next;
  end

  // ****************************************************************
  // event status, mask and interrupt
  // ****************************************************************
  logic [pif_pkg::EVENT_COUNT-1:0] event_status;
  wire  [pif_pkg::EVENT_COUNT-1:0] event_set = {cmp_hit, cap_hit};
  wire  [pif_pkg::EVENT_COUNT-1:0] event_clr =
    wr_sts ? wdata[pif_pkg::EVENT_COUNT-1:0] : '0;

  pif_sticky_bits #(
    .WIDTH (pif_pkg::EVENT_COUNT)
  ) u_status (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .set_i     (event_set),
    .clr_i     (event_clr),
    .bits_o    (event_status)
  );

  assign irq_o = |(event_status & event_mask_reg);

  // core request: global enable, then either the core group or peripherals
  wire periph_pending = |(peripheral_flags_1_reg & peripheral_enables_1_reg)
                      | (capture_compare_two_flag_reg & capture_compare_two_enable_reg);
  wire core_pending   = |(core_irq_control_reg[5:3] & core_irq_control_reg[2:0]);
  assign cpu_irq_o = core_irq_control_reg[pif_pkg::GIE_BIT]
                   & ((core_irq_control_reg[pif_pkg::PEIE_BIT] & periph_pending)
                      | core_pending);

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire [7:0] flags_2_view = {7'h00, capture_compare_two_flag_reg} & pif_pkg::FLAGS_2_MASK;
  logic [31:0] rd_word;
  always_comb begin
    rd_word = pif_pkg::ZERO_WORD;
    case (bus_addr)
      pif_pkg::OFS_CORE_IRQ_CONTROL:     rd_word[7:0] = core_irq_control_reg;
      pif_pkg::OFS_OPTION_CONFIG:        rd_word[7:0] = option_config_reg;
      pif_pkg::OFS_PERIPHERAL_FLAGS_1:   rd_word[7:0] = peripheral_flags_1_reg;
      pif_pkg::OFS_PERIPHERAL_FLAGS_2:   rd_word[7:0] = flags_2_view;
      pif_pkg::OFS_PERIPHERAL_ENABLES_1: rd_word[7:0] = peripheral_enables_1_reg;
      pif_pkg::OFS_PERIPHERAL_ENABLES_2: rd_word[0]   = capture_compare_two_enable_reg;
      pif_pkg::OFS_CCP2_MODE:            rd_word[1:0] = ccp_mode_reg;
      pif_pkg::OFS_EVENT_STATUS:         rd_word[pif_pkg::EVENT_COUNT-1:0] = event_status;
      pif_pkg::OFS_EVENT_MASK:           rd_word[pif_pkg::EVENT_COUNT-1:0] = event_mask_reg;
      default:                           rd_word = pif_pkg::ZERO_WORD;
    endcase
  end

  // rd strobe is the data phase; mux is combinational from latched addr
  assign hrdata_o    = bus_rd ? rd_word : pif_pkg::ZERO_WORD;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign ccp_mode_o  = ccp_mode_reg;

endmodule

/* testbench/pif_chk.sv */
/* port checker for peripheral_interrupt_flags, bound to the top module.
   assumes hready_i is tied to hreadyout_o (one slave on the bus). */
module pif_chk (
  input wire logic        ref_clk_i,       // core clock
  input wire logic        rst_i,           // sync reset, high
  input wire logic        hsel_i,          // ahb select
  input wire logic [31:0] haddr_i,         // ahb address
  input wire logic [1:0]  htrans_i,        // ahb transfer type
  input wire logic        hwrite_i,        // ahb write
  input wire logic        hready_i,        // ahb ready in
  input wire logic [31:0] hrdata_o,        // ahb read data
  input wire logic        hreadyout_o,     // ahb ready out
  input wire logic        hresp_o,         // ahb response
  input wire logic        capture_event_i, // capture pulse
  input wire logic        compare_event_i, // compare pulse
  input wire logic [1:0]  ccp_mode_o,      // unit mode
  input wire logic        irq_o            // event interrupt
);
  // ****************************************************************
  // data phase tracking
  // ****************************************************************
  logic       wr_dp;
  logic       rd_dp;
  logic [7:0] ofs;
  always_ff @(posedge ref_clk_i) begin
    wr_dp <= !rst_i && hsel_i && hready_i && htrans_i[1] && hwrite_i;
    rd_dp <= !rst_i && hsel_i && hready_i && htrans_i[1] && !hwrite_i;
    ofs   <= haddr_i[7:0];
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_cap; capture_event_i && ccp_mode_o == pif_pkg::MODE_CAPTURE; endsequence
  sequence s_cmp; compare_event_i && ccp_mode_o == pif_pkg::MODE_COMPARE; endsequence
  a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus not ready or not okay");
  a_event_holds: assert property ((s_cap or s_cmp) ##0 !wr_dp |=> !$fell(irq_o))
    else $error("irq fell right after an event");
  a_flag_sticky: assert property ($fell(irq_o) |-> $past(wr_dp))
    else $error("irq fell without a software write");
  a_pwm_ignored: assert property ((capture_event_i || compare_event_i) && !wr_dp
    && (ccp_mode_o == 2'd0 || ccp_mode_o == 2'd3) |=> !$rose(irq_o))
    else $error("event outside capture or compare mode raised irq");
  a_upper_zero: assert property (rd_dp && ofs == pif_pkg::OFS_PERIPHERAL_FLAGS_2
    |-> hrdata_o[31:1] == 31'h0) else $error("upper flag bits read nonzero");
  a_idle_rdata: assert property (!rd_dp |-> hrdata_o == pif_pkg::ZERO_WORD)
    else $error("read data outside data phase");
  a_mode_stable: assert property (!wr_dp |=> $stable(ccp_mode_o))
    else $error("mode changed without a write");
  a_mode_read: assert property (rd_dp && ofs == pif_pkg::OFS_CCP2_MODE
    |-> hrdata_o == {30'h0, ccp_mode_o}) else $error("mode readback differs");
endmodule
bind peripheral_interrupt_flags pif_chk pif_chk_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .capture_event_i(capture_event_i), .compare_event_i(compare_event_i),
  .ccp_mode_o(ccp_mode_o), .irq_o(irq_o));

/* testbench/cc_unit_model.sv */
/* capture/compare unit model: one-cycle event pulses on request.
   assumes dly_i is held steady while a request is in flight. */
module cc_unit_model (
  input  wire logic       ref_clk_i, // core clock
  input  wire logic       req_i,     // raise one event
  input  wire logic       kind_i,    // 0 capture, 1 compare
  input  wire logic [1:0] dly_i,     // answer delay, 0 prompt
  output logic            capture_o, // capture pulse
  output logic            compare_o  // compare pulse
);
  logic [3:0] cap_sr;
  logic [3:0] cmp_sr;
  always_ff @(posedge ref_clk_i) begin
    cap_sr <= {cap_sr[2:0], req_i & ~kind_i};
    cmp_sr <= {cmp_sr[2:0], req_i & kind_i};
  end
  assign capture_o = cap_sr[dly_i];
  assign compare_o = cmp_sr[dly_i];
endmodule

/* testbench/peripheral_interrupt_flags_tb.sv */
/* self-checking bench for peripheral_interrupt_flags over ahb-lite.
   assumes a single master; hready_i follows hreadyout_o. */
module peripheral_interrupt_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, hsel, hwrite, hrdy, hresp, cap, cmp, cpu, irq, req, kind;
  logic [1:0]  htrans, mode, dly;
  logic [7:0]  f1set, rnd;
  logic [31:0] haddr, hwdata, hrdata, q;
  int          num_errors, n_compared;
  peripheral_interrupt_flags peripheral_interrupt_flags_inst (.ref_clk_i(clk), .rst_i(rst),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .flags_1_set_i(f1set), .capture_event_i(cap), .compare_event_i(cmp),
    .ccp_mode_o(mode), .cpu_irq_o(cpu), .irq_o(irq));
  cc_unit_model cc_unit_model_inst (.ref_clk_i(clk), .req_i(req), .kind_i(kind),
    .dly_i(dly), .capture_o(cap), .compare_o(cmp));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] exp_flag(input logic [1:0] m, input logic k);
    return {31'h0, (m == pif_pkg::MODE_CAPTURE && !k) || (m == pif_pkg::MODE_COMPARE && k)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("errors=%0d compared=%0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // waits for hready, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic f);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    req    <= f;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    req    <= 1'b0;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 1'b0);
    chk(q, e);
  endtask
  task automatic lvl_chk(input logic s, input logic e);
    @(posedge clk);
    chk({31'h0, s ? cpu : irq}, {31'h0, e});
  endtask
  task automatic ev(input logic k, input logic [1:0] d);
    kind <= k;
    dly  <= d;
    req  <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst, hsel, hwrite, req, kind, htrans, dly, f1set, haddr, hwdata} = '0;
    rst = 1'b1;
    rnd = 8'h48;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a <= 'h24; a += 4) begin
      rd_chk(8'(a), (a == 'h04) ? 32'h0000_00FF : 32'h0000_0000);
    end
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF, 1'b0);
    rd_chk(8'h0C, 32'h0000_0001);
    rnd = lfsr(rnd);
    f1set <= rnd;
    @(posedge clk);
    f1set <= 8'h00;
    rd_chk(8'h08, {24'h0, rnd});
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        bus(1'b1, 8'h18, m, 1'b0);
        bus(1'b1, 8'h0C, 32'h0, 1'b0);
        bus(1'b1, 8'h1C, 32'h3, 1'b0);
        rnd = lfsr(rnd);
        ev(k[0], rnd[1:0]);
        repeat (rnd[7:4]) @(posedge clk);
        rd_chk(8'h0C, exp_flag(m[1:0], k[0]));
        rd_chk(8'h1C, exp_flag(m[1:0], k[0]) << k);
      end
    end
    bus(1'b1, 8'h18, 32'h1, 1'b0);
    bus(1'b1, 8'h1C, 32'h3, 1'b0);
    bus(1'b1, 8'h20, 32'h1, 1'b0);
    ev(1'b0, 2'd2);
    lvl_chk(1'b0, 1'b1);
    bus(1'b1, 8'h20, 32'h0, 1'b0);
    lvl_chk(1'b0, 1'b0);
    bus(1'b1, 8'h20, 32'h1, 1'b0);
    lvl_chk(1'b0, 1'b1);
    bus(1'b1, 8'h1C, 32'h1, 1'b0);
    lvl_chk(1'b0, 1'b0);
    bus(1'b1, 8'h0C, 32'h0, 1'b0);
    bus(1'b1, 8'h14, 32'h1, 1'b0);
    bus(1'b1, 8'h00, 32'hC0, 1'b0);
    lvl_chk(1'b1, 1'b0);
    ev(1'b0, 2'd0);
    lvl_chk(1'b1, 1'b1);
    dly <= 2'd0;
    kind <= 1'b0;
    bus(1'b1, 8'h0C, 32'h0, 1'b1);
    rd_chk(8'h0C, 32'h0000_0001);
    bus(1'b1, 8'h1C, 32'h1, 1'b1);
    rd_chk(8'h1C, 32'h0000_0001);
    give_verdict();
  end
endmodule
